// ==== dic_input_capture.sv ====
// Functional notes
// - Pad input can bypass capture and delay, reaching core as data or clock.
// - Enabled input delay is fixed or chosen by a 4-bit delay select.
// - Single rate mode captures the input in one system clock register.
// - Double rate mode samples rise and fall edges of strobe or edge clock.
// - Both double rate streams are resynchronised into the system clock.
// - Gearbox mode turns one double rate pad into four parallel streams.
// - Gearbox first pair passes the edge clock domain, then system clock.
// - Gearbox capture exists only in left and right side blocks.
// - Polarity input chooses which clock edge drives synchronisation registers.
// - Transfer latch governs moves from synchronisation to transfer registers.
// - Strobe read control makes strobe clock use, polarity and transfer latch.
// - Polarity selection moves the sync capture edge to avoid timing violations.
// - Polarity is re-evaluated at the start of every read cycle.
// - First strobe rising edge after preamble sets the sync polarity; here lvl_pol loads once the read start has passed rd_s.
// - Polarity and latch controls are adjustable for read leveling.
//
// Implementation choices: the register addresses and the APB interface to the registers.
module dic_input_capture
    import dic_pkg::*;
#(
    parameter bit GEAR_CAPABLE = 1'b1
)
(
    // System clock and reset.
    input  wire logic        mclk,
    input  wire logic        reset,
    // APB slave.
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Link side: strobe (or upstream-muxed edge clock) and pad data.
    input  wire logic        delayed_strobe_clock,
    input  wire logic        pad_input_data,
    // Core controls.
    input  wire logic [3:0]  input_delay_select,
    input  wire logic        read_start,
    // Core data outputs.
    output logic             comb_input_bypass,
    output logic             input_clock_bypass,
    output logic             sdr_data,
    output dic_word_s        ddr_word,
    output logic             data_valid,
    // Strobe read control observation.
    output logic             sync_clock_polarity,
    output logic             sync_transfer_latch
);

    // System clock domain state.
    typedef struct packed {
        logic [1:0]  pad_s;
        logic [15:0] hist;
        logic        byp;
        logic        sdr;
        dic_cfg_s    cfg;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic [2:0]  req_s;
        logic        ack;
        dic_word_s   word;
        logic        valid;
        logic [1:0]  pol_s;
        logic [1:0]  ovr_s;
        logic        rd_tog;
    } dic_ms_s;

    // Link domain state on the strobe rising edge.
    typedef struct packed {
        dic_cfg_s [1:0] csync;
        logic [1:0]     rd_s;
        logic [1:0]     ack_s;
        logic           rd_seen;
        dic_lk_e        st;
        logic           pol;
        logic           ph;
        logic           lat;
        logic           rise;
        logic [1:0]     psync;
        logic [1:0]     pair_a;
        dic_word_s      hold;
        logic           req;
        logic           ovr;
    } dic_ls_s;

    // Link domain state on the strobe falling edge.
    typedef struct packed {
        logic       fall;
        logic [1:0] nsync;
    } dic_ns_s;

    dic_ms_s   m_q, m_d;
    dic_ls_s   l_q, l_d;
    dic_ns_s   n_q, n_d;
    logic [3:0] tap;
    logic       dly_bit;
    logic       new_rd;
    logic [1:0] sel;
    dic_cfg_s   lc;
    dic_cfg_s   wcfg;
    dic_word_s  word;

    // Outputs come straight from state flip-flops.
    assign prdata              = m_q.prdata;
    assign pready              = m_q.pready;
    assign pslverr             = m_q.pslverr;
    assign comb_input_bypass   = m_q.byp;
    assign input_clock_bypass  = m_q.byp;
    assign sdr_data            = m_q.sdr;
    assign ddr_word            = m_q.word;
    assign data_valid          = m_q.valid;
    assign sync_clock_polarity = l_q.pol;
    assign sync_transfer_latch = l_q.lat;

    // System clock next state: pad sync, delay, capture, crossing and APB.
    always_comb begin
        m_d = m_q;
        wcfg = dic_cfg_s'(pwdata[6:0]);
        m_d.pad_s = {m_q.pad_s[0], pad_input_data};
        m_d.hist = {m_q.hist[14:0], m_q.pad_s[1]};
        tap = m_q.cfg.dly_dyn ? input_delay_select : DIC_FIXED_TAP;
        dly_bit = m_q.cfg.dly_en ? m_q.hist[tap] : m_q.pad_s[1];
        m_d.byp = m_q.pad_s[1];
        if (m_q.cfg.mode == DIC_MODE_SDR) begin
            m_d.sdr = dly_bit;
        end
        if (read_start) begin
            m_d.rd_tog = ~m_q.rd_tog;
        end
        // Request toggle from the link is synchronised, then its edge loads the word.
        m_d.req_s = {m_q.req_s[1:0], l_q.req};
        m_d.valid = 1'b0;
        if (m_q.req_s[2] != m_q.req_s[1]) begin
            m_d.word = l_q.hold;
            m_d.valid = 1'b1;
            m_d.ack = m_q.req_s[1];
        end
        m_d.pol_s = {m_q.pol_s[0], l_q.pol};
        m_d.ovr_s = {m_q.ovr_s[0], l_q.ovr};
        // Read data and error are set up in the setup phase, valid in access.
        m_d.pready = 1'b1;
        if (psel && !penable) begin
            m_d.pslverr = 1'b0;
            m_d.prdata = 32'h0000_0000;
            case (paddr)
                DIC_CTRL_OFS: m_d.prdata[6:0] = m_q.cfg;
                DIC_STAT_OFS: begin
                    m_d.prdata[DIC_STAT_POL_BIT] = m_q.pol_s[1];
                    m_d.prdata[DIC_STAT_OVR_BIT] = m_q.ovr_s[1];
                    m_d.prdata[DIC_STAT_GEAR_BIT] = GEAR_CAPABLE;
                end
                DIC_DATA_OFS: m_d.prdata[4:0] = {m_q.word, m_q.sdr};
                default: m_d.pslverr = 1'b1;
            endcase
        end
        // Writes land at the access edge; unsupported gearbox falls back to DDR.
        if (psel && penable && m_q.pready && pwrite && paddr == DIC_CTRL_OFS) begin
            m_d.cfg = wcfg;
            if (wcfg.mode == DIC_MODE_GEAR && !GEAR_CAPABLE) begin
                m_d.cfg.mode = DIC_MODE_DDR;
            end
        end
    end

    // System clock registers.
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            m_q <= '0;
            m_q.cfg <= dic_cfg_s'(DIC_CTRL_RST);
        end else begin
            m_q <= m_d;
        end
    end

    // Falling edge capture and falling edge synchronisation copy.
    always_comb begin
        n_d = n_q;
        n_d.fall = pad_input_data;
        n_d.nsync = {l_q.rise, n_q.fall};
    end

    always_ff @(negedge delayed_strobe_clock or posedge reset) begin
        if (reset) begin
            n_q <= '0;
        end else begin
            n_q <= n_d;
        end
    end

    // Link domain: strobe read control, sync select, latch and gearbox.
    always_comb begin
        l_d = l_q;
        word = '0;
        lc = l_q.csync[1];
        l_d.csync = {l_q.csync[0], m_q.cfg};
        l_d.rd_s = {l_q.rd_s[0], m_q.rd_tog};
        l_d.ack_s = {l_q.ack_s[0], m_q.ack};
        l_d.rise = pad_input_data;
        l_d.psync = {l_q.rise, n_q.fall};
        new_rd = l_q.rd_s[1] != l_q.rd_seen;
        sel = l_q.pol ? n_q.nsync : l_q.psync;
        // First rising edge seen after a new read re-evaluates polarity.
        if (lc.generic) begin
            l_d.st = DIC_LK_BURST;
            l_d.pol = lc.lvl_pol;
            l_d.rd_seen = l_q.rd_s[1];
        end else if (new_rd) begin
            l_d.st = DIC_LK_BURST;
            l_d.pol = lc.lvl_pol;
            l_d.rd_seen = l_q.rd_s[1];
            l_d.ph = 1'b0;
            l_d.ovr = 1'b0;
        end
        l_d.lat = 1'b0;
        case (l_q.st)
            DIC_LK_IDLE: l_d.ph = 1'b0;
            DIC_LK_BURST: begin
                if (lc.mode != DIC_MODE_SDR) begin
                    l_d.ph = ~l_q.ph;
                    l_d.lat = (l_q.ph == lc.lvl_lat);
                end
            end
            default: l_d.st = DIC_LK_IDLE;
        endcase
        if (!l_q.ph) begin
            l_d.pair_a = sel;
        end
        // Gearbox builds four streams; DDR keeps the latest pair.
        if (lc.mode == DIC_MODE_GEAR) begin
            word = {l_q.pair_a, sel};
        end else begin
            word = {sel, 2'b00};
        end
        if (l_q.lat) begin
            if (l_q.req == l_q.ack_s[1]) begin
                l_d.hold = word;
                l_d.req = ~l_q.req;
            end else begin
                l_d.ovr = 1'b1;
            end
        end
    end

    always_ff @(posedge delayed_strobe_clock or posedge reset) begin
        if (reset) begin
            l_q <= '0;
        end else begin
            l_q <= l_d;
        end
    end

    // System clock checks.
    AST_BYPASS_PATH: assert property (
        @(posedge mclk) disable iff (reset)
        !$past(reset, 3) |-> comb_input_bypass == $past(pad_input_data, 3)
    ) else $error("bypass does not follow pad after sync");

    AST_SDR_CAPTURE: assert property (
        @(posedge mclk) disable iff (reset)
        (m_q.cfg.mode == DIC_MODE_SDR && !m_q.cfg.dly_en) |=> sdr_data == $past(m_q.pad_s[1])
    ) else $error("sdr capture mismatch");

    // Fixed tap of four adds five cycles of history to the capture.
    AST_FIXED_DELAY: assert property (
        @(posedge mclk) disable iff (reset)
        (m_q.cfg.mode == DIC_MODE_SDR && m_q.cfg.dly_en && !m_q.cfg.dly_dyn)[*7]
        |=> sdr_data == $past(m_q.pad_s[1], 6)
    ) else $error("fixed delay tap wrong");

    AST_DELIVER: assert property (
        @(posedge mclk) disable iff (reset)
        (m_q.req_s[2] != m_q.req_s[1]) |=> data_valid && ddr_word == $past(l_q.hold)
    ) else $error("crossed word not delivered");

    AST_VALID_PULSE: assert property (
        @(posedge mclk) disable iff (reset)
        data_valid |=> !data_valid
    ) else $error("valid longer than one cycle");

    AST_GEAR_GATE: assert property (
        @(posedge mclk) disable iff (reset)
        !GEAR_CAPABLE |-> m_q.cfg.mode != DIC_MODE_GEAR
    ) else $error("gearbox enabled where absent");

    AST_APB_ERR: assert property (
        @(posedge mclk) disable iff (reset)
        (psel && !penable && paddr > DIC_DATA_OFS) |=> pslverr
    ) else $error("unmapped address without error");

    // Link domain checks.
    AST_POL_HOLD: assert property (
        @(posedge delayed_strobe_clock) disable iff (reset)
        (l_q.st == DIC_LK_BURST && !new_rd && !lc.generic) |=> $stable(l_q.pol)
    ) else $error("polarity changed inside burst");

    AST_DETECT: assert property (
        @(posedge delayed_strobe_clock) disable iff (reset)
        (new_rd && !lc.generic) |=> l_q.st == DIC_LK_BURST && l_q.pol == $past(lc.lvl_pol)
    ) else $error("read start did not set polarity");

    AST_LATCH_SPACING: assert property (
        @(posedge delayed_strobe_clock) disable iff (reset)
        sync_transfer_latch |=> !sync_transfer_latch ##1 (l_q.st != DIC_LK_BURST
            || lc.mode == DIC_MODE_SDR || $past(new_rd) || sync_transfer_latch)
    ) else $error("transfer latch spacing wrong");

    // In generic mode there is no detection, so polarity tracks the leveling bit.
    AST_GENERIC_FOLLOW: assert property (
        @(posedge delayed_strobe_clock) disable iff (reset)
        lc.generic |=> l_q.pol == $past(lc.lvl_pol)
    ) else $error("generic polarity does not follow control");

    // A detection is followed by a transfer latch within two phase periods.
    COV_DETECT: cover property (
        @(posedge delayed_strobe_clock) disable iff (reset)
        new_rd && !lc.generic ##[1:4] sync_transfer_latch
    );

    COV_GEAR_WORD: cover property (
        @(posedge mclk) disable iff (reset)
        data_valid && m_q.cfg.mode == DIC_MODE_GEAR
    );

    COV_OVERRUN: cover property (
        @(posedge delayed_strobe_clock) disable iff (reset)
        l_q.lat && l_q.req != l_q.ack_s[1]
    );

    COV_DYN_DELAY: cover property (
        @(posedge mclk) disable iff (reset)
        m_q.cfg.dly_en && m_q.cfg.dly_dyn && input_delay_select == 4'hf
    );

endmodule

// ==== dic_pkg.sv ====
package dic_pkg;

    // Register byte offsets on the APB slave.
    localparam logic [7:0] DIC_CTRL_OFS = 8'h00;
    localparam logic [7:0] DIC_STAT_OFS = 8'h04;
    localparam logic [7:0] DIC_DATA_OFS = 8'h08;

    // Control register field positions.
    localparam int DIC_CTRL_MODE_LSB = 0;
    localparam int DIC_CTRL_GEN_BIT  = 2;
    localparam int DIC_CTRL_DLY_BIT  = 3;
    localparam int DIC_CTRL_DYN_BIT  = 4;
    localparam int DIC_CTRL_POL_BIT  = 5;
    localparam int DIC_CTRL_LAT_BIT  = 6;

    // Status register field positions.
    localparam int DIC_STAT_POL_BIT  = 0;
    localparam int DIC_STAT_OVR_BIT  = 1;
    localparam int DIC_STAT_GEAR_BIT = 2;

    // Reset values and timing.
    localparam logic [6:0] DIC_CTRL_RST  = 7'h00;
    localparam logic [3:0] DIC_FIXED_TAP = 4'h4;

    // Capture modes.
    typedef enum logic [1:0] {
        DIC_MODE_SDR  = 2'h0,
        DIC_MODE_DDR  = 2'h1,
        DIC_MODE_GEAR = 2'h2
    } dic_mode_e;

    // Strobe read control states, Gray coded.
    typedef enum logic [1:0] {
        DIC_LK_IDLE  = 2'h0,
        DIC_LK_BURST = 2'h1
    } dic_lk_e;

    // Control register contents.
    typedef struct packed {
        logic      lvl_lat;
        logic      lvl_pol;
        logic      dly_dyn;
        logic      dly_en;
        logic      generic;
        dic_mode_e mode;
    } dic_cfg_s;

    // One captured word: first and second rise/fall pairs.
    typedef struct packed {
        logic gear_stream_rise_first;
        logic gear_stream_fall_first;
        logic gear_stream_rise_second;
        logic gear_stream_fall_second;
    } dic_word_s;

endpackage

// ==== dic_strobe_model.sv ====
module dic_strobe_model (
    // Link lines toward the capture block.
    output logic strobe,
    output logic pad
);
    timeunit 1ns;
    timeprecision 100ps;

    // Termination holds the idle strobe low and the pad starts low.
    initial begin
        strobe = 1'b0;
        pad    = 1'b0;
    end

    // Sets the pad level for single rate traffic, just after a clock edge.
    task automatic set_pad(input logic v);
        pad <= v;
    endtask

    // One read: a low preamble, then n strobe periods with centred data.
    task automatic burst(input int n, input logic rv, input logic fv);
        #1.7;
        strobe = 1'b0;
        #12;
        repeat (n) begin
            pad = rv;
            #3 strobe = 1'b1;
            #3 pad = fv;
            #3 strobe = 1'b0;
            #3;
        end
        // A released line shows the inverse of its last value.
        pad = ~fv;
    endtask
endmodule

// ==== testbench.sv ====
module testbench import dic_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;

    logic        mclk = 1'b0;
    logic        reset = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        read_start = 1'b0;
    logic        watch = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  dsel = 4'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        strobe;
    logic        pad;
    logic        comb_bp;
    logic        clk_bp;
    logic        sdr;
    logic        dvalid;
    logic        pol;
    logic        lat;
    dic_word_s   word;
    logic [31:0] rd;
    logic        er;
    logic [3:0]  exp_word;
    int          error_cnt = 0;
    int          n_compared = 0;
    int          n_words = 0;
    logic [31:0] cfg_tab [4] = '{32'h00, 32'h08, 32'h18, 32'h18};
    logic [3:0]  sel_tab [4] = '{4'h0, 4'h0, 4'h0, 4'hf};
    int          lat_tab [4];

    // System clock at 100 MHz.
    always #5 mclk = ~mclk;

    dic_strobe_model u_mem (.strobe(strobe), .pad(pad));

    dic_input_capture #(.GEAR_CAPABLE(1'b1)) u_dut (
        .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .delayed_strobe_clock(strobe), .pad_input_data(pad),
        .input_delay_select(dsel), .read_start(read_start),
        .comb_input_bypass(comb_bp), .input_clock_bypass(clk_bp), .sdr_data(sdr),
        .ddr_word(word), .data_valid(dvalid), .sync_clock_polarity(pol),
        .sync_transfer_latch(lat)
    );

    // Counts a comparison and reports a mismatch at once.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // One APB transfer; the answer is taken at the edge where pready is high.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        int i;
        @(posedge mclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge mclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (i == 20) begin
            error_cnt++;
            results();
        end
    endtask

    // A read burst, with a control write landing in the middle of it.
    task automatic read_burst(input logic go, input logic rv, input logic fv,
                              input logic [31:0] mid);
        n_words = 0;
        if (go) begin
            read_start <= 1'b1;
            cyc(1);
            read_start <= 1'b0;
        end
        fork
            u_mem.burst(16, rv, fv);
            begin
                // Words latched before the new mode and detection settle carry the
                // previous burst, so checking starts once the link has caught up.
                cyc(12);
                watch = 1'b1;
                apb(1'b1, DIC_CTRL_OFS, mid);
            end
        join
        cyc(10);
        watch = 1'b0;
    endtask

    // Every word handed to the core while watch is set carries the pattern of the current burst.
    always @(negedge mclk) begin
        if (watch && dvalid === 1'b1) begin
            n_words++;
            check(32'(word), 32'(exp_word));
        end
    end

    // Main sequence.
    initial begin
        lat_tab = '{3, int'(DIC_FIXED_TAP) + 4, 4, 19};
        fork
            u_mem.burst(3, 1'b0, 1'b0);
            cyc(6);
        join
        reset <= 1'b0;
        apb(1'b0, DIC_CTRL_OFS, 32'h0);
        check(rd, 32'(DIC_CTRL_RST));
        apb(1'b0, DIC_STAT_OFS, 32'h0);
        check(rd, 32'h1 << DIC_STAT_GEAR_BIT);
        apb(1'b1, 8'h0c, 32'h7f);
        check(32'(er), 32'h1);
        apb(1'b1, DIC_STAT_OFS, 32'h3);
        apb(1'b0, DIC_STAT_OFS, 32'h0);
        check(rd, 32'h1 << DIC_STAT_GEAR_BIT);
        for (int m = 0; m < 3; m++) begin
            apb(1'b1, DIC_CTRL_OFS, 32'(m));
            apb(1'b0, DIC_CTRL_OFS, 32'h0);
            check(rd, 32'(m));
        end
        $display("test registers done");
        // Pad to core latency for each delay setting.
        for (int k = 0; k < 4; k++) begin
            apb(1'b1, DIC_CTRL_OFS, cfg_tab[k]);
            dsel <= sel_tab[k];
            u_mem.set_pad(1'b0);
            cyc(30);
            u_mem.set_pad(1'b1);
            cyc(lat_tab[k] - 1);
            #1 check(32'(sdr), 32'h0);
            cyc(1);
            #1 check(32'(sdr), 32'h1);
            check(32'({comb_bp, clk_bp}), 32'h3);
        end
        $display("test delay done");
        exp_word = 4'b1000;
        apb(1'b1, DIC_CTRL_OFS, 32'h21);
        read_burst(1'b1, 1'b1, 1'b0, 32'h01);
        check(32'(pol), 32'h1);
        check(32'(n_words != 0), 32'h1);
        apb(1'b0, DIC_STAT_OFS, 32'h0);
        check(rd & 32'h1, 32'h1);
        read_burst(1'b1, 1'b1, 1'b0, 32'h01);
        check(32'(pol), 32'h0);
        apb(1'b0, DIC_DATA_OFS, 32'h0);
        check(rd >> 1, 32'(exp_word));
        $display("test memory ddr done");
        exp_word = 4'b0101;
        apb(1'b1, DIC_CTRL_OFS, 32'h22);
        read_burst(1'b1, 1'b0, 1'b1, 32'h22);
        check(32'(n_words != 0), 32'h1);
        check(32'(pol), 32'h1);
        $display("test gearbox done");
        exp_word = 4'b1000;
        apb(1'b1, DIC_CTRL_OFS, 32'h05);
        read_burst(1'b0, 1'b1, 1'b0, 32'h25);
        check(32'(pol), 32'h1);
        $display("test generic done");
        results();
    end
endmodule
